// >>> dbv_regs_map.svh
// Register map constants of the dual buck voltage-select and status bank.
// Assumes inclusion by bare name from files that use the constants.
`ifndef DBV_REGS_MAP_SVH
`define DBV_REGS_MAP_SVH

// ----------------------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------------------
`define DBV_ADDR_SEL1      8'h00
`define DBV_ADDR_SEL2      8'h01
`define DBV_ADDR_COM1      8'h02
`define DBV_ADDR_COM2      8'h03
`define DBV_ADDR_STATUS    8'h04

// ----------------------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------------------
`define DBV_SEL_RESET      8'h00
`define DBV_COM_RESET      8'h00
`define DBV_COM_WMASK      8'h77
`define DBV_SYNC_RESET     10'h0300

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DBV_SEL_COMMIT_BIT 7
`define DBV_SEL_CODE_MSB   6
`define DBV_COM_SLEW_MSB   6
`define DBV_COM_SLEW_LSB   4
`define DBV_COM_MODE_MSB   2
`define DBV_COM_MODE_LSB   1
`define DBV_COM_OFF_BIT    0
`define DBV_STAT_OT_BIT    2
`define DBV_STAT_PG2_BIT   1
`define DBV_STAT_PG1_BIT   0

// ----------------------------------------------------------------------------
// Voltage code scale, in millivolts
// ----------------------------------------------------------------------------
`define DBV_VID_BASE_MV    11'h02A8
`define DBV_VID_STEP_MV    11'h000A

// ----------------------------------------------------------------------------
// Serial frame counts
// ----------------------------------------------------------------------------
`define DBV_BITS_PER_BYTE  4'h8
`define DBV_LAST_TX_BIT    4'h7

`endif

// >>> dbv_pkg.sv
// Types shared by the dual buck register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package dbv_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h2,
    ST_REG  = 4'h3,
    ST_RACK = 4'h4,
    ST_WR   = 4'h5,
    ST_WACK = 4'h6,
    ST_RD   = 4'h7,
    ST_MACK = 4'h8
  } dbv_i2c_state_t;

  typedef enum logic [1:0] {
    LL_PIN  = 2'h0,
    LL_FPWM = 2'h1,
    LL_AUTO = 2'h2,
    LL_RSVD = 2'h3
  } dbv_ll_mode_t;

  typedef enum logic [2:0] {
    IDX_SEL1   = 3'h0,
    IDX_SEL2   = 3'h1,
    IDX_COM1   = 3'h2,
    IDX_COM2   = 3'h3,
    IDX_STATUS = 3'h4,
    IDX_NONE   = 3'h7
  } dbv_reg_idx_t;

endpackage

// >>> dbv_ramp_if.sv
// Carrier between the register bank and one channel's voltage ramp.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface dbv_ramp_if;
  logic [6:0]  target_code;
  logic        commit;
  logic [2:0]  slew;
  logic        cycle_tick;
  logic [6:0]  cur_code;
  logic [10:0] cur_mv;
  logic        at_target;

  modport ctrl (output target_code, output commit, output slew, output cycle_tick,
                input cur_code, input cur_mv, input at_target);
  modport ramp (input target_code, input commit, input slew, input cycle_tick,
                output cur_code, output cur_mv, output at_target);
endinterface

// >>> dbv_ramp.sv
// Per-channel output voltage code ramp, paced by switching cycles.
// Assumes cycle_tick is a one-clock pulse per converter switching cycle.
`timescale 1ns/100ps
`include "dbv_regs_map.svh"
module dbv_ramp (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  dbv_ramp_if.ramp  bus
);

  logic [6:0]  div_cnt_q;
  logic [6:0]  cur_q;
  logic [10:0] mv_q;
  logic [7:0]  div_span;
  logic [6:0]  div_last;
  logic        step_due;
  logic [10:0] mv_d;

  // ----------------------------------------------------------------------------
  // Step pacing: one code step per 2^slew cycles
  // ----------------------------------------------------------------------------
  assign div_span = (8'h01 << bus.slew) - 8'h01;
  assign div_last = div_span[6:0];  // RULE2
  assign step_due = bus.cycle_tick && (div_cnt_q == div_last);
  assign mv_d     = `DBV_VID_BASE_MV + ({4'h0, cur_q} * `DBV_VID_STEP_MV);  // RULE10

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt_q <= 7'h00;
      cur_q     <= 7'h00;
      mv_q      <= `DBV_VID_BASE_MV;
    end else begin
      mv_q <= mv_d;
      // Uncommitted code tracks the register so commit starts from it, no ramp
      if (!bus.commit) begin  // RULE12
        cur_q     <= bus.target_code;
        div_cnt_q <= 7'h00;
      end else if (bus.cycle_tick) begin
        div_cnt_q <= step_due ? 7'h00 : div_cnt_q + 7'h01;
        if (step_due && cur_q < bus.target_code) begin  // RULE2
          cur_q <= cur_q + 7'h01;
        end else if (step_due && cur_q > bus.target_code) begin
          cur_q <= cur_q - 7'h01;
        end
      end
    end
  end

  assign bus.cur_code  = cur_q;
  assign bus.cur_mv    = mv_q;
  assign bus.at_target = (cur_q == bus.target_code);

endmodule

// >>> dbv_regs.sv
// Register bank of a dual step-down converter, reached over a two-wire serial
// slave: voltage select, command and status registers with slew-paced ramps.
// Assumes all pin inputs are asynchronous and sw_cycle_i rises once per
// switching cycle at well under half the system clock rate.
//
// Summary of operation
// (RULE1) Channel-2 command sits at byte 0x03, read/write, fields zero after reset.
// (RULE2) Slew field bits 6:4 = N steps the target by one 10 mV code every 2^N switching cycles.
// (RULE3) Light-load field bits 2:1: 00 follows the mode pin, 10 is automatic pulse-skip, 11 reserved.
// (RULE4) Light-load code 01 forces PWM; the host must not write 11.
// (RULE5) Command bit 0 set to 1 shuts the channel down in software; 0 leaves it enabled.
// (RULE6) Status at byte 0x04 is read-only, zero by default, bits 7:3 reserved.
// (RULE7) Status bit 2 reads 1 while the die is above 125 C.
// (RULE8) Status bit 1 reads 1 while output 2 is in its power-good window.
// (RULE9) Status bit 0 reads 1 while output 1 is in its power-good window.
// (RULE10) A 7-bit code maps to 680 mV plus 10 mV per step, 0x7F giving 1950 mV.
// (RULE11) Reserved command and status bits read zero and ignore writes.
// (RULE12) Voltage-select bit 7 must be 1 for the code to replace the start-up voltage; here bit 7 at 0 applies it at once, bit 7 at 1 ramps to it.
// (RULE13) In parallel current-sharing mode channel 2 follows the channel-1 registers.
// (RULE14) Register writes are refused while both hardware enable pins are low.
`timescale 1ns/100ps
`include "dbv_regs_map.svh"
module dbv_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h60
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output wire logic             sda_o,
  output wire logic             sda_oe_o,
  input  wire logic             channel1_hw_enable_pin_i,
  input  wire logic             channel2_hw_enable_pin_i,
  input  wire logic             share_mode_i,
  input  wire logic             mode_pin_i,
  input  wire logic             die_over_temp_i,
  input  wire logic             output1_in_regulation_i,
  input  wire logic             output2_in_regulation_i,
  input  wire logic             sw_cycle_i,
  output wire logic [1:0][6:0]  vid_code_o,
  output wire logic [1:0][10:0] vid_mv_o,
  output wire logic [1:0]       vid_active_o,
  output wire logic [1:0]       vid_settled_o,
  output wire logic [1:0]       output_off_o,
  output wire logic [1:0]       light_load_skip_o
);

  // ----------------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------------
  // Reserved low addresses would collide with bus special codes
  if (DEV_ADDR < 7'h08) begin : g_bad_addr
    $error("DEV_ADDR falls in the reserved address range");
  end

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  function automatic dbv_pkg::dbv_reg_idx_t reg_index(input logic [7:0] addr);
    if (addr == `DBV_ADDR_SEL1) begin
      return dbv_pkg::IDX_SEL1;
    end else if (addr == `DBV_ADDR_SEL2) begin
      return dbv_pkg::IDX_SEL2;
    end else if (addr == `DBV_ADDR_COM1) begin
      return dbv_pkg::IDX_COM1;
    end else if (addr == `DBV_ADDR_COM2) begin
      return dbv_pkg::IDX_COM2;
    end else if (addr == `DBV_ADDR_STATUS) begin
      return dbv_pkg::IDX_STATUS;
    end else begin
      return dbv_pkg::IDX_NONE;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------------
  logic [9:0] async_in;
  logic [9:0] meta_q;
  logic [9:0] sync_q;
  logic       scl_prev_q;
  logic       sda_prev_q;
  logic       tick_prev_q;

  assign async_in = {scl_i, sda_i, channel1_hw_enable_pin_i, channel2_hw_enable_pin_i, share_mode_i,
                     mode_pin_i, die_over_temp_i, output2_in_regulation_i, output1_in_regulation_i,
                     sw_cycle_i};

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q      <= `DBV_SYNC_RESET;
      sync_q      <= `DBV_SYNC_RESET;
      scl_prev_q  <= 1'b1;
      sda_prev_q  <= 1'b1;
      tick_prev_q <= 1'b0;
    end else begin
      meta_q      <= async_in;
      sync_q      <= meta_q;
      scl_prev_q  <= sync_q[9];
      sda_prev_q  <= sync_q[8];
      tick_prev_q <= sync_q[0];
    end
  end

  wire scl_s      = sync_q[9];
  wire sda_s      = sync_q[8];
  wire ch1_en_s   = sync_q[7];
  wire ch2_en_s   = sync_q[6];
  wire share_s    = sync_q[5];
  wire modepin_s  = sync_q[4];
  wire ot_s       = sync_q[3];
  wire pg2_s      = sync_q[2];
  wire pg1_s      = sync_q[1];
  wire tick_s     = sync_q[0];

  wire scl_rise    = scl_s & ~scl_prev_q;
  wire scl_fall    = ~scl_s & scl_prev_q;
  wire start_det   = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_det    = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire cycle_pulse = tick_s & ~tick_prev_q;
  wire hw_shutdown = ~ch1_en_s & ~ch2_en_s;

  // ----------------------------------------------------------------------------
  // Serial slave state machine
  // ----------------------------------------------------------------------------
  dbv_pkg::dbv_i2c_state_t state_q;
  logic [3:0]              bit_cnt_q;
  logic [7:0]              shift_q;
  logic [7:0]              tx_q;
  logic [7:0]              ptr_q;
  logic                    rw_q;
  logic                    nack_q;
  logic [7:0]              rd_byte;
  logic [7:0]              status_byte;
  logic [1:0][7:0]         sel_q;
  logic [1:0][7:0]         com_q;
  dbv_pkg::dbv_reg_idx_t   reg_idx;

  assign reg_idx = reg_index(ptr_q);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q   <= dbv_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      rw_q      <= 1'b0;
      nack_q    <= 1'b0;
    end else if (start_det) begin
      state_q   <= dbv_pkg::ST_ADDR;
      bit_cnt_q <= 4'h0;
    end else if (stop_det) begin
      state_q <= dbv_pkg::ST_IDLE;
    end else if (scl_rise) begin
      case (state_q)
        dbv_pkg::ST_ADDR, dbv_pkg::ST_REG, dbv_pkg::ST_WR: begin
          shift_q   <= {shift_q[6:0], sda_s};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        dbv_pkg::ST_MACK: nack_q <= sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_q)
        dbv_pkg::ST_ADDR: begin
          if (bit_cnt_q == `DBV_BITS_PER_BYTE) begin
            rw_q    <= shift_q[0];
            state_q <= (shift_q[7:1] == DEV_ADDR) ? dbv_pkg::ST_AACK : dbv_pkg::ST_IDLE;
          end
        end
        dbv_pkg::ST_AACK: begin
          bit_cnt_q <= 4'h0;
          if (rw_q) begin
            tx_q    <= rd_byte;
            ptr_q   <= ptr_q + 8'h01;
            state_q <= dbv_pkg::ST_RD;
          end else begin
            state_q <= dbv_pkg::ST_REG;
          end
        end
        dbv_pkg::ST_REG: begin
          if (bit_cnt_q == `DBV_BITS_PER_BYTE) begin
            ptr_q   <= shift_q;
            state_q <= dbv_pkg::ST_RACK;
          end
        end
        dbv_pkg::ST_RACK: begin
          bit_cnt_q <= 4'h0;
          state_q   <= dbv_pkg::ST_WR;
        end
        dbv_pkg::ST_WR: begin
          if (bit_cnt_q == `DBV_BITS_PER_BYTE) begin
            state_q <= dbv_pkg::ST_WACK;
          end
        end
        dbv_pkg::ST_WACK: begin
          bit_cnt_q <= 4'h0;
          ptr_q     <= ptr_q + 8'h01;
          state_q   <= dbv_pkg::ST_WR;
        end
        dbv_pkg::ST_RD: begin
          if (bit_cnt_q == `DBV_LAST_TX_BIT) begin
            bit_cnt_q <= 4'h0;
            state_q   <= dbv_pkg::ST_MACK;
          end else begin
            tx_q      <= {tx_q[6:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        dbv_pkg::ST_MACK: begin
          if (nack_q) begin
            state_q <= dbv_pkg::ST_IDLE;
          end else begin
            tx_q    <= rd_byte;
            ptr_q   <= ptr_q + 8'h01;
            state_q <= dbv_pkg::ST_RD;
          end
        end
        default: state_q <= dbv_pkg::ST_IDLE;
      endcase
    end
  end

  // Acknowledge our address and every written byte, drive zero read bits low; the line is only pulled
  wire ack_slot = (state_q == dbv_pkg::ST_AACK) || (state_q == dbv_pkg::ST_RACK) ||
                  (state_q == dbv_pkg::ST_WACK);
  assign sda_oe_o = ack_slot || ((state_q == dbv_pkg::ST_RD) && !tx_q[7]);
  assign sda_o    = 1'b0;

  // ----------------------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------------------
  assign status_byte = {5'h00, ot_s, pg2_s, pg1_s};  // RULE6 RULE7 RULE8 RULE9 RULE11

  assign rd_byte = (reg_idx == dbv_pkg::IDX_SEL1)   ? sel_q[0] :
                   (reg_idx == dbv_pkg::IDX_SEL2)   ? sel_q[1] :
                   (reg_idx == dbv_pkg::IDX_COM1)   ? com_q[0] :
                   (reg_idx == dbv_pkg::IDX_COM2)   ? com_q[1] :  // RULE1
                   (reg_idx == dbv_pkg::IDX_STATUS) ? status_byte :
                   8'h00;

  // ----------------------------------------------------------------------------
  // Register write path and per-channel control
  // ----------------------------------------------------------------------------
  // Update lands on the clock fall closing the data byte, ahead of its ack
  wire wr_fire = scl_fall && (state_q == dbv_pkg::ST_WR) && (bit_cnt_q == `DBV_BITS_PER_BYTE) &&
                 !hw_shutdown;  // RULE14

  logic [1:0] off_q;
  logic [1:0] skip_q;

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    wire sel_hit = wr_fire && (reg_idx == dbv_pkg::dbv_reg_idx_t'(dbv_pkg::IDX_SEL1 + ch));
    wire com_hit = wr_fire && (reg_idx == dbv_pkg::dbv_reg_idx_t'(dbv_pkg::IDX_COM1 + ch));

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        sel_q[ch] <= `DBV_SEL_RESET;
        com_q[ch] <= `DBV_COM_RESET;  // RULE1
      end else begin
        if (sel_hit) begin
          sel_q[ch] <= shift_q;
        end
        if (com_hit) begin
          com_q[ch] <= shift_q & `DBV_COM_WMASK;  // RULE1 RULE11
        end
      end
    end

    // Shared mode: channel 2 mirrors channel 1 so both phases agree
    wire [7:0] eff_sel = (ch == 1 && share_s) ? sel_q[0] : sel_q[ch];  // RULE13
    wire [7:0] eff_com = (ch == 1 && share_s) ? com_q[0] : com_q[ch];  // RULE13
    dbv_pkg::dbv_ll_mode_t ll_mode;
    assign ll_mode = dbv_pkg::dbv_ll_mode_t'(eff_com[`DBV_COM_MODE_MSB:`DBV_COM_MODE_LSB]);

    // Reserved code falls back to the pin rather than an undefined mode
    wire skip_d = (ll_mode == dbv_pkg::LL_AUTO) ? 1'b1 :  // RULE3
                  (ll_mode == dbv_pkg::LL_FPWM) ? 1'b0 :  // RULE4
                  modepin_s;                              // RULE3

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        off_q[ch]  <= 1'b0;
        skip_q[ch] <= 1'b0;
      end else begin
        off_q[ch]  <= eff_com[`DBV_COM_OFF_BIT];  // RULE5
        skip_q[ch] <= skip_d;
      end
    end

    dbv_ramp_if rbus ();
    assign rbus.target_code = eff_sel[`DBV_SEL_CODE_MSB:0];
    assign rbus.commit      = eff_sel[`DBV_SEL_COMMIT_BIT];  // RULE12
    assign rbus.slew        = eff_com[`DBV_COM_SLEW_MSB:`DBV_COM_SLEW_LSB];  // RULE2
    assign rbus.cycle_tick  = cycle_pulse;

    dbv_ramp u_ramp (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .bus       (rbus.ramp)
    );

    assign vid_code_o[ch]    = rbus.cur_code;
    assign vid_mv_o[ch]      = rbus.cur_mv;  // RULE10
    assign vid_active_o[ch]  = rbus.commit;
    assign vid_settled_o[ch] = rbus.at_target;
  end

  assign output_off_o      = off_q;
  assign light_load_skip_o = skip_q;

endmodule

// >>> dbv_regs_properties.sv
// Concurrent checks on the register bank's serial pins and channel outputs.
// Assumes binding onto dbv_regs; every input lives in the system clock domain.
`timescale 1ns/100ps
module dbv_regs_properties (
  input wire logic             sys_clk_i,
  input wire logic             rst_i,
  input wire logic             scl_i,
  input wire logic             sda_i,
  input wire logic             sda_o,
  input wire logic             sda_oe_o,
  input wire logic             sw_cycle_i,
  input wire logic [1:0][6:0]  vid_code_o,
  input wire logic [1:0][10:0] vid_mv_o,
  input wire logic [1:0]       vid_active_o,
  input wire logic [1:0]       vid_settled_o,
  input wire logic [1:0]       output_off_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // --------------------------------------------------------------------
  // Helper: clocks since the switching-cycle pin last rose
  // --------------------------------------------------------------------
  logic       sw_prev_q;
  logic [3:0] since_sw_q;
  logic [3:0] since_sw_d;
  assign since_sw_d = (sw_cycle_i && !sw_prev_q) ? 4'h0 : ((since_sw_q == 4'hF) ? 4'hF : since_sw_q + 4'h1);
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      since_sw_q <= 4'hF;
      sw_prev_q  <= 1'b0;
    end else begin
      since_sw_q <= since_sw_d;
      sw_prev_q  <= sw_cycle_i;
    end
  end

  // --------------------------------------------------------------------
  // Sequences and assertions
  // --------------------------------------------------------------------
  sequence s_ramp_move;
    vid_active_o[1] && $past(vid_active_o[1]) && $changed(vid_code_o[1]);
  endsequence
  sequence s_start_seen;
    $fell(sda_i) && scl_i;
  endsequence
  sequence s_direct_miss;
    !vid_active_o[0] && !vid_settled_o[0];
  endsequence

  a_sda_pull_only: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data pull changed while clock high");
  a_start_quiet: assert property (s_start_seen |-> !sda_oe_o [*8])
    else $error("data pulled right after start");
  a_mv_code_one: assert property (vid_mv_o[0] == 11'h02A8 + 11'h000A * {4'h0, $past(vid_code_o[0])})
    else $error("channel 1 millivolts off its code");
  a_mv_code_two: assert property (vid_mv_o[1] == 11'h02A8 + 11'h000A * {4'h0, $past(vid_code_o[1])})
    else $error("channel 2 millivolts off its code");
  a_cfg_on_fall: assert property ($changed({vid_active_o[0], output_off_o[0]}) |-> !scl_i)
    else $error("channel 1 setting changed outside a write");
  a_ramp_unit_step: assert property (s_ramp_move |->
      (vid_code_o[1] == $past(vid_code_o[1]) + 7'h01) || (vid_code_o[1] == $past(vid_code_o[1]) - 7'h01))
    else $error("ramp moved more than one code");
  // Two synchroniser flops plus the ramp flop after the pin rises
  a_ramp_paced: assert property (s_ramp_move |-> since_sw_q == 4'h2)
    else $error("ramp moved without a switching cycle");
  a_direct_follow: assert property (s_direct_miss |=> vid_settled_o[0])
    else $error("uncommitted code did not follow target");
endmodule

bind dbv_regs dbv_regs_properties u_dbv_regs_properties (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .sw_cycle_i(sw_cycle_i), .vid_code_o(vid_code_o), .vid_mv_o(vid_mv_o), .vid_active_o(vid_active_o),
  .vid_settled_o(vid_settled_o), .output_off_o(output_off_o)
);

// >>> dbv_host_model.sv
// Two-wire host controller model doing single-byte register writes and reads.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/100ps
module dbv_host_model #(
  parameter logic [6:0] ADDR = 7'h60
) (
  input  wire logic sys_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // Data moves only while clock is low; 8 clocks per phase beats the slave minimum
  task automatic xfer(input logic b, output logic r);
    sda_o = b;
    hold(4);
    scl_o = 1'b1;
    hold(7);
    r = sda_i;
    hold(1);
    scl_o = 1'b0;
    hold(4);
  endtask

  task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], r);
      q[i] = r;
    end
    xfer(ack_in, ack);
  endtask

  task automatic start();
    sda_o = 1'b1;
    hold(4);
    scl_o = 1'b1;
    hold(8);
    sda_o = 1'b0;
    hold(8);
    scl_o = 1'b0;
    hold(4);
  endtask

  task automatic stop();
    sda_o = 1'b0;
    hold(4);
    scl_o = 1'b1;
    hold(8);
    sda_o = 1'b1;
    hold(8);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, q, k0);
    xbyte(a, 1'b1, q, k1);
    xbyte(d, 1'b1, q, k2);
    stop();
    ok = !(k0 | k1 | k2);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2, nak;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, q, k0);
    xbyte(a, 1'b1, q, k1);
    start();
    xbyte({ADDR, 1'b1}, 1'b1, q, k2);
    // Line released for the device's bits, then no-acknowledge ends the read
    xbyte(8'hFF, 1'b1, d, nak);
    stop();
    ok = !(k0 | k1 | k2) & nak;
  endtask
endmodule

// >>> dual_buck_vid_status_regs_tb_top.sv
// Self-checking bench for the dual buck register bank over its two-wire port.
// Assumes the host model and all bench inputs change at falling clock edges.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module dual_buck_vid_status_regs_tb_top;
  logic             clk, rst, scl, host_sda, sda_oe, sda_line;
  logic             ch1_hw_en, ch2_hw_en, share, mode_pin, hot, pg1, pg2, sw;
  logic [1:0][6:0]  code;
  logic [1:0][10:0] mv;
  logic [1:0]       active, settled, off, skip;
  int               miscompares = 0;
  int               samples_checked = 0;
  logic [6:0]       r_start [3] = '{7'h7E, 7'h05, 7'h40};
  logic [6:0]       r_tgt   [3] = '{7'h7F, 7'h0A, 7'h41};
  logic [2:0]       r_slew  [3] = '{3'h0, 3'h1, 3'h7};

  // Open-drain data line with pull-up
  assign sda_line = host_sda & ~sda_oe;

  dbv_host_model u_dbv_host_model (.sys_clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_o(host_sda));
  dbv_regs u_dbv_regs (
    .sys_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe),
    .channel1_hw_enable_pin_i(ch1_hw_en), .channel2_hw_enable_pin_i(ch2_hw_en), .share_mode_i(share),
    .mode_pin_i(mode_pin), .die_over_temp_i(hot), .output1_in_regulation_i(pg1),
    .output2_in_regulation_i(pg2), .sw_cycle_i(sw), .vid_code_o(code), .vid_mv_o(mv),
    .vid_active_o(active), .vid_settled_o(settled), .output_off_o(off), .light_load_skip_o(skip)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop();
    if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic do_wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_dbv_host_model.wr(a, d, ok);
    `CHK(ok, 1'b1)
  endtask

  task automatic check_rd(input logic [7:0] a, input logic [7:0] e);
    logic       ok;
    logic [7:0] d;
    u_dbv_host_model.rd(a, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      sw = 1'b1;
      repeat (6) @(negedge clk);
      sw = 1'b0;
      repeat (6) @(negedge clk);
    end
  endtask

  initial begin
    int need;
    {rst, ch1_hw_en, ch2_hw_en, share, mode_pin, hot, pg1, pg2, sw} = 9'b1_1100_0000;
    repeat (7) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check_rd(8'h03, 8'h00);
    check_rd(8'h04, 8'h00);
    `CHK(off, 2'b00)
    // Reserved bits set, mode field kept off the reserved code
    do_wr(8'h03, 8'hFB);
    check_rd(8'h03, 8'h73);
    `CHK(off[1], 1'b1)
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 2; p++) begin
        mode_pin = p[0];
        do_wr(8'h03, {5'h00, m[1:0], 1'b0});
        `CHK(off[1], 1'b0)
        `CHK(skip[1], (m == 1) ? 1'b0 : ((m == 2) ? 1'b1 : p[0]))
      end
    end
    for (int b = 0; b < 3; b++) begin
      {hot, pg2, pg1} = 3'b001 << b;
      check_rd(8'h04, {5'h00, 3'b001 << b});
    end
    {hot, pg2, pg1} = 3'b000;
    do_wr(8'h04, 8'hFF);
    check_rd(8'h04, 8'h00);
    do_wr(8'h07, 8'hAA);
    check_rd(8'h07, 8'h00);
    {ch1_hw_en, ch2_hw_en} = 2'b00;
    do_wr(8'h03, 8'h01);
    {ch1_hw_en, ch2_hw_en} = 2'b11;
    // Still holds the automatic light-load write that closed the loop
    check_rd(8'h03, 8'h04);
    ch1_hw_en = 1'b0;
    do_wr(8'h03, 8'h01);
    check_rd(8'h03, 8'h01);
    ch1_hw_en = 1'b1;
    do_wr(8'h00, 8'h7F);
    `CHK(mv[0], 11'h079E)
    `CHK(code[0], 7'h7F)
    `CHK(active[0], 1'b0)
    for (int i = 0; i < 3; i++) begin
      do_wr(8'h01, {1'b0, r_start[i]});
      `CHK(code[1], r_start[i])
      do_wr(8'h03, {1'b0, r_slew[i], 4'h0});
      do_wr(8'h01, {1'b1, r_tgt[i]});
      `CHK(active[1], 1'b1)
      need = int'(r_tgt[i] - r_start[i]) << r_slew[i];
      pulse(need - 1);
      `CHK(code[1], r_tgt[i] - 7'h01)
      pulse(1);
      `CHK(code[1], r_tgt[i])
      `CHK(settled[1], 1'b1)
      `CHK(mv[1], 11'h02A8 + 11'h000A * {4'h0, r_tgt[i]})
    end
    do_wr(8'h02, 8'h01);
    share = 1'b1;
    repeat (6) @(negedge clk);
    `CHK(off, 2'b11)
    `CHK(code[1], 7'h7F)
    `CHK(skip, {2{mode_pin}})
    report_and_stop();
  end

  // Whole sequence needs about 18600 clocks
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule
